// *** pkg/rct_pkg.sv ***
// Purpose: constants and types for the relay, counter and timer block
// Assumes: 20 MHz system clock, half-cycle tick supplied from outside
// Notes: pulse widths in ms are converted to half-cycle counts at run time, timer periods to microseconds
package rct_pkg;
  localparam int unsigned RCT_CLK_HZ = 20000000;
  localparam int unsigned RCT_NUM_RELAYS = 4;
  localparam int unsigned RCT_NUM_COUNTERS = 8;
  localparam int unsigned RCT_NUM_DIN = 8;
  localparam int unsigned RCT_NUM_TIMERS = 4;
  localparam int unsigned RCT_NUM_SOURCES = 6;
  // Pulse width limits and default, ms
  localparam logic [9:0] RCT_PULSE_MS_MIN = 10'h014;
  localparam logic [9:0] RCT_PULSE_MS_MAX = 10'h3e8;
  localparam logic [9:0] RCT_PULSE_MS_DEF = 10'h064;
  // Energy weight in tenths of a unit: 0.1 to 1000.0, default 1.0
  localparam logic [13:0] RCT_WEIGHT_MIN = 14'h0001;
  localparam logic [13:0] RCT_WEIGHT_MAX = 14'h2710;
  localparam logic [13:0] RCT_WEIGHT_DEF = 14'h000a;
  // Counter multiplier 1 to 9999, default 1
  localparam logic [13:0] RCT_MULT_MIN = 14'h0001;
  localparam logic [13:0] RCT_MULT_MAX = 14'h270f;
  localparam logic [13:0] RCT_MULT_DEF = 14'h0001;
  // Counters wrap modulo 100000000
  localparam logic [26:0] RCT_CNT_MODULUS = 27'h5f5e100;
  // Timer period, ms, up to 24 hours
  localparam logic [26:0] RCT_TMR_MS_MAX = 27'h5265c00;
  // Half-cycle length in microseconds, 8333 at 60 Hz and 10000 at 50 Hz
  localparam logic [13:0] RCT_HALF_US_60 = 14'h208d;
  localparam logic [13:0] RCT_HALF_US_50 = 14'h2710;
  localparam logic [9:0] RCT_US_PER_MS = 10'h3e8;
  localparam logic [2:0] RCT_DIN_NONE = 3'h0;

  typedef enum logic [1:0] {
    RCT_MODE_FOLLOW = 2'b00,
    RCT_MODE_HOLD = 2'b01,
    RCT_MODE_PULSE = 2'b10,
    RCT_MODE_TRANS = 2'b11
  } rct_mode_t;

  typedef enum logic [1:0] {
    RCT_PS_IDLE = 2'b00,
    RCT_PS_ON = 2'b01,
    RCT_PS_PAUSE = 2'b10
  } rct_pstate_t;
endpackage

// *** rtl/rct_relay_counter_timer.sv ***
// Purpose: relay outputs, event counters and interval timers
// Assumes: half_tick_i pulses once per half-cycle scan; inputs synchronous
// Notes: all timing is counted in half-cycles, never in system clocks
//
// Behaviour
// - Four relays, numbered by expansion module connection order.
// - Follow mode: relay active exactly while its setpoint operates.
// - Hold mode: set by setpoint, cleared by a reset command or when its relay is not present.
// - Pulse mode: active for width, then inactive for width, then rest.
// - Transition mode: each command toggles the relay and holds it.
// - Normal polarity energizes when active; inverting polarity inverts.
// - Retention applies only to relays in hold mode.
// - Non-retentive relays start inactive; retentive ones restore state.
// - Pulse width 20 to 1000 ms, default 100, rounded up to half-cycles.
// - Pause between pulses equals the applied pulse width.
// - Energy source link works only in pulse or transition mode.
// - One energy pulse per programmed weight of accumulator advance.
// - Eight independent eight-digit event counters.
// - Counter input mask selects none, one or several of eight digital inputs.
// - Each linked input pulse adds the multiplier, 1 to 9999.
// - Several inputs may feed one counter; all are counted.
// - Setpoint actions increment any counter regardless of linkage.
// - Counter values are readable and lie within 0 to 99999999.
// - Four interval timers raise an internal event on expiry.
// - Timer period in ms up to 24 hours, rounded up to half-cycles.
// - Timer runs while period is non-zero; zero stops it.
// - Commands are evaluated once per half-cycle scan.
// - Pulsed events clear at the end of each scan.
`timescale 1ns/1ps
module rct_relay_counter_timer
  import rct_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic half_tick_i,
  input wire logic line_50hz_i,
  input wire logic [3:0] relay_present_i,
  input wire logic [7:0] relay_mode_i,
  input wire logic [3:0] relay_invert_i,
  input wire logic [3:0] relay_retain_i,
  input wire logic [3:0] relay_saved_i,
  input wire logic [39:0] relay_width_ms_i,
  input wire logic [11:0] relay_source_i,
  input wire logic [55:0] relay_weight_i,
  input wire logic [3:0] setpoint_active_i,
  input wire logic [3:0] relay_cmd_i,
  input wire logic [3:0] relay_release_i,
  input wire logic [5:0] energy_tick_i,
  input wire logic [7:0] digital_in_pulse_i,
  input wire logic [63:0] cnt_input_sel_i,
  input wire logic [111:0] cnt_mult_i,
  input wire logic [7:0] cnt_setpoint_inc_i,
  input wire logic [107:0] tmr_period_ms_i,
  output logic [3:0] relay_coil_o,
  output logic [3:0] relay_active_o,
  output logic [215:0] cnt_value_o,
  output logic [3:0] tmr_event_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] active;
    logic [3:0][1:0] pst;
    logic [3:0][6:0] phase;
    logic [3:0][6:0] width_hc;
    logic [3:0][13:0] eacc;
    logic [3:0] epend;
    logic [7:0][26:0] cnt;
    logic [3:0][36:0] tacc_us;
    logic [3:0] tevt;
    logic started;
  } rct_state_t;

  rct_state_t st_reg;
  rct_state_t st_next;

  // Round ms up to whole half-cycles; at least one half-cycle
  function automatic logic [6:0] ms_to_hc(input logic [9:0] ms,
                                          input logic [13:0] half_us);
    logic [19:0] us;
    logic [19:0] q;
    us = 20'(ms) * 20'(RCT_US_PER_MS);
    q = (us + 20'(half_us) - 20'h00001) / 20'(half_us);
    if (q == 20'h00000) begin
      q = 20'h00001;
    end
    return q[6:0];
  endfunction

  function automatic logic [9:0] clamp_width(input logic [9:0] ms);
    if (ms == 10'h000) begin
      return RCT_PULSE_MS_DEF;
    end else if (ms < RCT_PULSE_MS_MIN) begin
      return RCT_PULSE_MS_MIN;
    end else if (ms > RCT_PULSE_MS_MAX) begin
      return RCT_PULSE_MS_MAX;
    end
    return ms;
  endfunction

  function automatic logic [26:0] cnt_add(input logic [26:0] v,
                                          input logic [26:0] a);
    logic [27:0] s;
    s = 28'(v) + 28'(a);
    // Both terms stay below the modulus, so one subtraction is enough
    if (s >= 28'(RCT_CNT_MODULUS)) begin
      s = s - 28'(RCT_CNT_MODULUS);
    end
    return s[26:0];
  endfunction

  logic [13:0] half_us;
  assign half_us = line_50hz_i ? RCT_HALF_US_50 : RCT_HALF_US_60;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0] md;
    logic cmd;
    logic [9:0] wms;
    logic [13:0] wt;
    logic [2:0] src;
    logic [26:0] add;
    logic [7:0] sel;
    logic [13:0] mul;
    logic [36:0] per_us;
    logic [26:0] per_ms;
    logic [7:0] etk;
    logic go;
    logic eset;
    st_next = st_reg;
    md = 2'b00;
    cmd = 1'b0;
    wms = 10'h000;
    wt = 14'h0000;
    src = 3'h0;
    add = 27'h0000000;
    sel = 8'h00;
    mul = 14'h0000;
    per_us = 37'h0;
    per_ms = 27'h0000000;
    // Source code 0 and the unused code 7 read a constant zero
    etk = {1'b0, energy_tick_i, 1'b0};
    go = 1'b0;
    eset = 1'b0;
    st_next.started = 1'b1;
    // Pulsed events last one scan only
    if (half_tick_i) begin
      st_next.tevt = 4'h0;
    end
    for (int r = 0; r < RCT_NUM_RELAYS; r++) begin
      md = relay_mode_i[2*r +: 2];
      wms = clamp_width(relay_width_ms_i[10*r +: 10]);
      wt = relay_weight_i[14*r +: 14];
      if (wt == 14'h0000) begin
        wt = RCT_WEIGHT_DEF;
      end else if (wt > RCT_WEIGHT_MAX) begin
        wt = RCT_WEIGHT_MAX;
      end
      src = relay_source_i[3*r +: 3];
      go = 1'b0;
      eset = 1'b0;
      // Energy ticks arrive in tenths of a unit
      if (etk[src] &&
          (md == RCT_MODE_PULSE || md == RCT_MODE_TRANS)) begin
        if (st_reg.eacc[r] + 14'h0001 >= wt) begin
          st_next.eacc[r] = 14'h0000;
          eset = 1'b1;
        end else begin
          st_next.eacc[r] = st_reg.eacc[r] + 14'h0001;
        end
      end
      if (!st_reg.started) begin
        // Power-up: only a retentive hold relay restores
        st_next.active[r] = relay_retain_i[r] && md == RCT_MODE_HOLD &&
                            relay_saved_i[r];
      end else if (half_tick_i && relay_present_i[r]) begin
        cmd = relay_cmd_i[r] || st_reg.epend[r];
        st_next.epend[r] = 1'b0;
        unique case (md)
          RCT_MODE_FOLLOW: begin
            st_next.active[r] = setpoint_active_i[r];
            st_next.pst[r] = RCT_PS_IDLE;
          end
          RCT_MODE_HOLD: begin
            if (setpoint_active_i[r]) begin
              st_next.active[r] = 1'b1;
            end else if (relay_release_i[r]) begin
              st_next.active[r] = 1'b0;
            end
            st_next.pst[r] = RCT_PS_IDLE;
          end
          RCT_MODE_PULSE: begin
            unique case (st_reg.pst[r])
              RCT_PS_IDLE: begin
                st_next.active[r] = 1'b0;
                go = cmd;
              end
              RCT_PS_ON: begin
                // A command during a pulse or pause is held back
                st_next.epend[r] = cmd;
                if (st_reg.phase[r] >= st_reg.width_hc[r]) begin
                  st_next.active[r] = 1'b0;
                  st_next.phase[r] = 7'h01;
                  st_next.pst[r] = RCT_PS_PAUSE;
                end else begin
                  st_next.phase[r] = st_reg.phase[r] + 7'h01;
                end
              end
              RCT_PS_PAUSE: begin
                if (st_reg.phase[r] >= st_reg.width_hc[r]) begin
                  // Pause is over here; a waiting command starts now
                  st_next.pst[r] = RCT_PS_IDLE;
                  go = cmd;
                end else begin
                  st_next.epend[r] = cmd;
                  st_next.phase[r] = st_reg.phase[r] + 7'h01;
                end
              end
              default: begin
                st_next.pst[r] = RCT_PS_IDLE;
                st_next.active[r] = 1'b0;
              end
            endcase
            if (go) begin
              st_next.width_hc[r] = ms_to_hc(wms, half_us);
              st_next.phase[r] = 7'h01;
              st_next.active[r] = 1'b1;
              st_next.pst[r] = RCT_PS_ON;
            end
          end
          RCT_MODE_TRANS: begin
            if (cmd) begin
              st_next.active[r] = !st_reg.active[r];
            end
            st_next.pst[r] = RCT_PS_IDLE;
          end
        endcase
      end else if (!relay_present_i[r]) begin
        st_next.active[r] = 1'b0;
      end
      // Set wins, so an energy pulse on a scan cycle is not lost
      if (eset) begin
        st_next.epend[r] = 1'b1;
      end
    end
    // Counters advance on the scan tick
    if (half_tick_i) begin
      for (int c = 0; c < RCT_NUM_COUNTERS; c++) begin
        add = 27'h0000000;
        sel = cnt_input_sel_i[8*c +: 8];
        mul = cnt_mult_i[14*c +: 14];
        if (mul == 14'h0000) begin
          mul = RCT_MULT_DEF;
        end else if (mul > RCT_MULT_MAX) begin
          mul = RCT_MULT_MAX;
        end
        // A mask per counter lets several inputs be summed
        for (int d = 0; d < RCT_NUM_DIN; d++) begin
          if (sel[d] && digital_in_pulse_i[d]) begin
            add = add + 27'(mul);
          end
        end
        if (cnt_setpoint_inc_i[c]) begin
          add = add + 27'h0000001;
        end
        st_next.cnt[c] = cnt_add(st_reg.cnt[c], add);
      end
      // Timers accumulate elapsed microseconds per half-cycle
      for (int t = 0; t < RCT_NUM_TIMERS; t++) begin
        per_ms = tmr_period_ms_i[27*t +: 27];
        if (per_ms > RCT_TMR_MS_MAX) begin
          per_ms = RCT_TMR_MS_MAX;
        end
        // A full day in microseconds needs 37 bits
        per_us = 37'(per_ms) * 37'(RCT_US_PER_MS);
        if (per_ms == 27'h0000000) begin
          st_next.tacc_us[t] = 37'h0;
        end else if (st_reg.tacc_us[t] + 37'(half_us) >= per_us) begin
          // Expiry lands on the first half-cycle at or past period
          st_next.tacc_us[t] = 37'h0;
          st_next.tevt[t] = 1'b1;
        end else begin
          st_next.tacc_us[t] = st_reg.tacc_us[t] + 37'(half_us);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    for (int r = 0; r < RCT_NUM_RELAYS; r++) begin
      relay_coil_o[r] = st_reg.active[r] ^ relay_invert_i[r];
    end
    for (int c = 0; c < RCT_NUM_COUNTERS; c++) begin
      cnt_value_o[27*c +: 27] = st_reg.cnt[c];
    end
  end
  assign relay_active_o = st_reg.active;
  assign tmr_event_o = st_reg.tevt;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_scan_cmd0;
    half_tick_i && relay_present_i[0] && st_reg.started;
  endsequence

  a_follow_tracks: assert property (
    s_scan_cmd0 and (relay_mode_i[1:0] == RCT_MODE_FOLLOW)
    |=> relay_active_o[0] == $past(setpoint_active_i[0]))
    else $error("follow relay did not track setpoint");
  a_hold_sets: assert property (
    half_tick_i && relay_present_i[1] && st_reg.started &&
    relay_mode_i[3:2] == RCT_MODE_HOLD && setpoint_active_i[1]
    |=> relay_active_o[1])
    else $error("hold relay did not set");
  a_hold_keeps: assert property (
    !half_tick_i && relay_present_i[1] &&
    relay_mode_i[3:2] == RCT_MODE_HOLD &&
    relay_active_o[1] && st_reg.started |=> relay_active_o[1])
    else $error("hold relay dropped between scans");
  a_trans_toggle: assert property (
    half_tick_i && relay_present_i[3] && st_reg.started &&
    relay_mode_i[7:6] == RCT_MODE_TRANS &&
    relay_cmd_i[3] && !st_reg.epend[3]
    |=> relay_active_o[3] != $past(relay_active_o[3]))
    else $error("transition relay did not toggle");
  a_coil_polarity: assert property (
    relay_coil_o == (relay_active_o ^ relay_invert_i))
    else $error("coil polarity wrong");
  a_pulse_start: assert property (
    half_tick_i && relay_present_i[2] && st_reg.started &&
    relay_mode_i[5:4] == RCT_MODE_PULSE &&
    st_reg.pst[2] == RCT_PS_IDLE && relay_cmd_i[2]
    |=> relay_active_o[2] && st_reg.pst[2] == RCT_PS_ON)
    else $error("pulse did not start");
  a_no_tick_still: assert property (
    !half_tick_i && st_reg.started |=> $stable(cnt_value_o))
    else $error("counter moved outside a scan");
  a_cnt_range: assert property (
    st_reg.cnt[7] < RCT_CNT_MODULUS)
    else $error("counter out of range");
  a_tmr_clear: assert property (
    half_tick_i && tmr_event_o[0] && tmr_period_ms_i[26:0] == 27'h0
    |=> !tmr_event_o[0])
    else $error("timer event not cleared");
  a_tmr_stopped: assert property (
    half_tick_i && tmr_period_ms_i[26:0] == 27'h0
    |=> st_reg.tacc_us[0] == 37'h0)
    else $error("stopped timer still runs");

endmodule

// *** verif/rct_load_model.sv ***
// Purpose: relay load that counts coil energize edges
// Assumes: coil drive is sampled on the system clock
// Notes: one 8-bit count per relay, wraps silently
`timescale 1ns/1ps
module rct_load_model (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] coil_i,
  output logic [31:0] pulse_cnt_o
);
  logic [3:0] coil_q;

  always_ff @(posedge sys_clk_i) begin
    coil_q <= coil_i;
    for (int i = 0; i < 4; i++) begin
      if (!reset_n_i) begin
        pulse_cnt_o[8*i+:8] <= 8'h00;
      end else if (coil_i[i] && !coil_q[i]) begin
        pulse_cnt_o[8*i+:8] <= pulse_cnt_o[8*i+:8] + 8'h01;
      end
    end
  end
endmodule

// *** verif/relay_counter_timer_io_tb.sv ***
// Purpose: self-checking bench for relays, counters and timers
// Assumes: 50 Hz line, so one half-cycle is 10 ms
// Notes: ticks every 4 clocks; notes are matched by tick index
`timescale 1ns/1ps
module relay_counter_timer_io_tb;
  import rct_pkg::*;
  typedef struct {int t; int k; int i; logic [26:0] v;} rct_note_t;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic half_tick_i = 1'b0;
  logic [3:0] sp_act = 4'h0, cmd = 4'h0, rel = 4'h0;
  logic [3:0] present = 4'hf, invert = 4'h1;
  logic [7:0] mode = 8'he4;
  logic [11:0] src = 12'h000;
  logic [5:0] etick = 6'h00;
  // Input masks per counter, counter 7 in the top byte
  logic [63:0] csel = 64'h8000002004090002;
  logic [7:0] din = 8'h00, sp_inc = 8'h00;
  logic [111:0] mult = '0;
  logic [107:0] tmr = '0;
  logic [3:0] coil, act, tev;
  logic [215:0] cval;
  logic [31:0] pulse_cnt;
  logic ticked = 1'b0;
  logic [13:0] m2;
  rct_note_t q[$];
  int drv_t = 0, mon_t = 0, n_fail = 0, comparisons = 0, cyc = 0;
  int ev[4];

  rct_relay_counter_timer dut (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .half_tick_i(half_tick_i), .line_50hz_i(1'b1),
    .relay_present_i(present), .relay_mode_i(mode),
    .relay_invert_i(invert), .relay_retain_i(4'h3), .relay_saved_i(4'h3),
    .relay_width_ms_i({10'h000, 10'h019, 20'h00000}),
    .relay_source_i(src), .relay_weight_i(56'h0),
    .setpoint_active_i(sp_act), .relay_cmd_i(cmd), .relay_release_i(rel),
    .energy_tick_i(etick), .digital_in_pulse_i(din),
    .cnt_input_sel_i(csel), .cnt_mult_i(mult),
    .cnt_setpoint_inc_i(sp_inc), .tmr_period_ms_i(tmr),
    .relay_coil_o(coil), .relay_active_o(act), .cnt_value_o(cval),
    .tmr_event_o(tev));

  rct_load_model load (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .coil_i(coil), .pulse_cnt_o(pulse_cnt));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // --------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------
  task automatic chk(input logic [26:0] seen, input logic [26:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic note_exp(input int k, input int i, input logic [26:0] v,
                          input int dt);
    int p;
    // Kept in tick order so a later note never blocks an earlier one
    p = q.size();
    while (p > 0 && q[p-1].t > drv_t + dt) begin
      p--;
    end
    q.insert(p, '{drv_t + dt, k, i, v});
  endtask

  function automatic logic [26:0] seen_val(input int k, input int i);
    case (k)
      0: seen_val = {26'h0, act[i]};
      1: seen_val = {26'h0, coil[i]};
      2: seen_val = cval[27*i+:27];
      default: seen_val = {26'h0, tev[i]};
    endcase
  endfunction

  // Outputs move one clock after a tick, so compare on the next negedge
  always @(posedge sys_clk_i) ticked <= reset_n_i & half_tick_i;
  always @(negedge sys_clk_i) begin
    if (ticked) begin
      mon_t++;
      for (int i = 0; i < 4; i++) ev[i] += int'(tev[i]);
      while (q.size() > 0 && q[0].t == mon_t) begin
        chk(seen_val(q[0].k, q[0].i), q[0].v);
        void'(q.pop_front());
      end
    end
  end

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk_i) half_tick_i = 1'b1;
      @(negedge sys_clk_i) half_tick_i = 1'b0;
      drv_t++;
      repeat (2) @(negedge sys_clk_i);
    end
  endtask

  initial begin
    void'($urandom(38));
    m2 = 14'h0001 + 14'($urandom % 9999);
    mult[13:0] = 14'h0007;
    mult[41:28] = m2;
    mult[111:98] = 14'h270f;
    repeat (8) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    note_exp(0, 1, 27'h1, 1);
    note_exp(0, 0, 27'h0, 1);
    note_exp(1, 0, 27'h1, 1);
    tick(1);
    rel[1] = 1'b1;
    note_exp(0, 1, 27'h0, 1);
    tick(1);
    rel[1] = 1'b0;
    sp_act = 4'h3;
    note_exp(0, 0, 27'h1, 1);
    note_exp(1, 0, 27'h0, 1);
    tick(1);
    sp_act = 4'h0;
    note_exp(0, 0, 27'h0, 1);
    note_exp(0, 1, 27'h1, 2);
    tick(2);
    rel[1] = 1'b1;
    note_exp(0, 1, 27'h0, 1);
    tick(1);
    rel[1] = 1'b0;
    cmd = 4'h4;
    note_exp(0, 2, 27'h1, 1);
    note_exp(1, 2, 27'h1, 1);
    note_exp(0, 2, 27'h1, 3);
    note_exp(0, 2, 27'h0, 4);
    note_exp(0, 2, 27'h0, 6);
    tick(1);
    cmd = 4'h8;
    note_exp(0, 3, 27'h1, 1);
    note_exp(0, 3, 27'h1, 3);
    tick(1);
    cmd = 4'h0;
    tick(2);
    cmd = 4'h8;
    note_exp(0, 3, 27'h0, 1);
    tick(1);
    cmd = 4'h0;
    tick(4);
    chk({19'h0, pulse_cnt[23:16]}, 27'h1);
    // Default weight is ten energy ticks per pulse
    src[11:9] = 3'h1;
    etick = 6'h01;
    repeat (9) @(negedge sys_clk_i);
    etick = 6'h00;
    note_exp(0, 3, 27'h0, 1);
    tick(1);
    etick = 6'h01;
    @(negedge sys_clk_i);
    etick = 6'h00;
    note_exp(0, 3, 27'h1, 1);
    tick(1);
    present = 4'h7;
    note_exp(0, 3, 27'h0, 1);
    tick(1);
    present = 4'hf;
    src = 12'h000;
    chk({19'h0, pulse_cnt[31:24]}, 27'h2);
    din = 8'h2b;
    sp_inc = 8'h42;
    note_exp(2, 0, 27'h7, 1);
    note_exp(2, 2, {12'h0, m2, 1'b0}, 1);
    note_exp(2, 4, 27'h1, 1);
    note_exp(2, 1, 27'h1, 1);
    note_exp(2, 6, 27'h1, 1);
    note_exp(2, 3, 27'h0, 1);
    tick(1);
    din = 8'h02;
    sp_inc = 8'h01;
    note_exp(2, 0, 27'hf, 1);
    tick(1);
    din = 8'h00;
    sp_inc = 8'h00;
    tmr[53:0] = {27'h19, 27'h1e};
    tick(2);
    for (int i = 0; i < 4; i++) ev[i] = 0;
    tick(28);
    chk({26'h0, ev[0] >= 9 && ev[0] <= 11}, 27'h1);
    chk(27'(ev[1]), 27'(ev[0]));
    chk(27'(ev[2]), 27'h0);
    tmr = '0;
    tick(2);
    ev[0] = 0;
    tick(6);
    chk(27'(ev[0]), 27'h0);
    din = 8'h80;
    tick(10000);
    note_exp(2, 7, 27'h5f5e0ff, 1);
    note_exp(2, 7, 27'h000270e, 2);
    tick(2);
    din = 8'h00;
    tick(1);
    chk(27'(q.size()), 27'h0);
    wrap_up();
  end
endmodule
